// *** design/stx_transceiver.sv ***
`timescale 1ns/1ps
module stx_transceiver #(
    parameter int unsigned IDLE_CYCLES = stx_pkg::IDLE_CYC,
    parameter int NUM_CH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] txLogicIn,
    input wire logic [NUM_CH-1:0] rxLineIn,
    input wire logic [NUM_CH-1:0] rxLineValid,
    input wire logic holdAwake,
    input wire logic shutdownN,
    output logic [NUM_CH-1:0] txLineOut,
    output logic [NUM_CH-1:0] txLineOe,
    output logic [NUM_CH-1:0] rxLogicOut,
    output logic [NUM_CH-1:0] rxLogicOe,
    output logic linePresent,
    output logic pumpOn,
    output logic irq
);
    if (IDLE_CYCLES < 2 || NUM_CH < 1 || NUM_CH > 8) begin : g_bad_param
        $error("stx_transceiver: unsupported parameter values");
    end

    localparam logic [stx_pkg::DLY_W-1:0] VALID_LAST = stx_pkg::DLY_W'(stx_pkg::VALID_CYC - 1);
    localparam logic [stx_pkg::DLY_W-1:0] INVALID_LAST = stx_pkg::DLY_W'(stx_pkg::INVALID_CYC - 1);

    stx_pwr_if pwr();

    stx_pwr_fsm #(
        .IDLE_CYCLES(IDLE_CYCLES)
    ) u_pwr_fsm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pwr(pwr)
    );

    logic [NUM_CH-1:0] txPrev_q;
    logic [NUM_CH-1:0] rxPrev_q;
    logic [NUM_CH-1:0] validPrev_q;
    logic [NUM_CH-1:0] rxSeen;
    logic holdSw_q;
    logic anyValid;
    logic drvOn;

    // Open inputs carry no data edges, only their arrival or loss
    assign rxSeen = rxLineIn & rxLineValid;
    assign anyValid = |rxLineValid;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txPrev_q <= '0;
            rxPrev_q <= '0;
            validPrev_q <= '0;
        end else begin
            txPrev_q <= txLogicIn;
            rxPrev_q <= rxSeen;
            validPrev_q <= rxLineValid;
        end
    end

    assign pwr.activity = |(txLogicIn ^ txPrev_q) | |(rxSeen ^ rxPrev_q) | |(rxLineValid ^ validPrev_q);
    assign pwr.autoEn = shutdownN && !holdAwake && !holdSw_q;

    // Drivers run only once the pump has fully restarted
    assign drvOn = shutdownN && pwr.state == stx_pkg::PWR_ACTIVE;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txLineOut <= '1;
            txLineOe <= '0;
        end else begin
            txLineOut <= ~txLogicIn;
            txLineOe <= {NUM_CH{drvOn}};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rxLogicOut <= '1;
            rxLogicOe <= '0;
        end else begin
            rxLogicOut <= ~rxLineIn | ~rxLineValid;
            rxLogicOe <= {NUM_CH{shutdownN}};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pumpOn <= 1'b0;
        end else begin
            pumpOn <= shutdownN && pwr.state != stx_pkg::PWR_DOWN;
        end
    end

    // Presence filter: a change must persist for its full delay
    logic [stx_pkg::DLY_W-1:0] presCnt_q;
    logic [stx_pkg::DLY_W-1:0] presLast;
    logic presFlip;

    assign presLast = linePresent ? INVALID_LAST : VALID_LAST;
    assign presFlip = anyValid != linePresent && presCnt_q == presLast;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            presCnt_q <= '0;
            linePresent <= 1'b0;
        end else if (anyValid == linePresent || presFlip) begin
            presCnt_q <= '0;
            linePresent <= anyValid;
        end else begin
            presCnt_q <= presCnt_q + 1'b1;
        end
    end

    // APB slave: one wait cycle, then the access completes
    logic apbDone;
    logic apbWait;
    logic addrOk;
    logic [31:0] rdData;
    logic [stx_pkg::IRQ_W-1:0] irqStat_q;
    logic [stx_pkg::IRQ_W-1:0] irqStat_d;
    logic [stx_pkg::IRQ_W-1:0] irqMask_q;
    logic [stx_pkg::IRQ_W-1:0] irqMask_d;
    logic [stx_pkg::IRQ_W-1:0] irqEvt;

    assign apbWait = psel && penable && !pready;
    assign apbDone = psel && penable && pready;

    always_comb begin
        rdData = '0;
        addrOk = 1'b1;
        unique case (paddr)
            stx_pkg::ADDR_CTRL: begin
                rdData[stx_pkg::CTRL_HOLD] = holdSw_q;
            end
            stx_pkg::ADDR_STATUS: begin
                rdData[stx_pkg::ST_PUMP] = pumpOn;
                rdData[stx_pkg::ST_DRV] = |txLineOe;
                rdData[stx_pkg::ST_RCV] = |rxLogicOe;
                rdData[stx_pkg::ST_LINE] = linePresent;
                rdData[stx_pkg::ST_STATE +: 2] = pwr.state;
            end
            stx_pkg::ADDR_IRQ_STAT: begin
                rdData[stx_pkg::IRQ_W-1:0] = irqStat_q;
            end
            stx_pkg::ADDR_IRQ_MASK: begin
                rdData[stx_pkg::IRQ_W-1:0] = irqMask_q;
            end
            default: begin
                addrOk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= apbWait;
            pslverr <= apbWait && !addrOk;
            prdata <= (apbWait && !pwrite) ? rdData : '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            holdSw_q <= stx_pkg::CTRL_HOLD_RST;
        end else if (apbDone && pwrite) begin
            if (paddr == stx_pkg::ADDR_CTRL) begin
                holdSw_q <= pwdata[stx_pkg::CTRL_HOLD];
            end
        end
    end

    // Next mask feeds irq, so a mask write and irq change together
    always_comb begin
        irqMask_d = irqMask_q;
        if (apbDone && pwrite && paddr == stx_pkg::ADDR_IRQ_MASK) begin
            irqMask_d = pwdata[stx_pkg::IRQ_W-1:0];
        end
    end

    // Sticky events; read clears only the bits it returned, new events win
    always_comb begin
        irqEvt = '0;
        irqEvt[stx_pkg::IRQ_DOWN] = pwr.enteredDown;
        irqEvt[stx_pkg::IRQ_WAKE] = pwr.wakeDone;
        irqEvt[stx_pkg::IRQ_LINE_UP] = presFlip && anyValid;
        irqEvt[stx_pkg::IRQ_LINE_DN] = presFlip && !anyValid;
        irqStat_d = irqStat_q;
        if (apbDone && !pwrite && paddr == stx_pkg::ADDR_IRQ_STAT) begin
            irqStat_d = irqStat_q & ~prdata[stx_pkg::IRQ_W-1:0];
        end
        irqStat_d = irqStat_d | irqEvt;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irqStat_q <= '0;
            irqMask_q <= stx_pkg::IRQ_MASK_RST;
            irq <= 1'b0;
        end else begin
            irqStat_q <= irqStat_d;
            irqMask_q <= irqMask_d;
            irq <= |(irqStat_d & irqMask_d);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Helper: run of cycles with a valid line while status is still low
    logic [stx_pkg::DLY_W-1:0] arriveRun_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n || !anyValid || linePresent) begin
            arriveRun_q <= '0;
        end else if (arriveRun_q != '1) begin
            arriveRun_q <= arriveRun_q + 1'b1;
        end
    end

    sequence s_line_arrives;
        anyValid && !linePresent;
    endsequence
    sequence s_apb_access;
        psel && penable && !pready;
    endsequence
    sequence s_apb_answer;
        pready ##1 !pready;
    endsequence

    a_shutdown_off: assert property (!shutdownN |=> txLineOe == '0 && rxLogicOe == '0 && !pumpOn)
        else $error("outputs not off in shutdown");
    a_rx_invert: assert property (shutdownN && rxLineValid[0] |=> rxLogicOe[0] && rxLogicOut[0] == !$past(rxLineIn[0]))
        else $error("receiver output not inverted line");
    a_rx_open_high: assert property (!rxLineValid[1] |=> rxLogicOut[1])
        else $error("open receiver output not high");
    a_tx_invert: assert property (txLineOe[0] |-> txLineOut[0] == !$past(txLogicIn[0]))
        else $error("driver output not inverted input");
    a_rx_on_in_down: assert property (shutdownN && pwr.state == stx_pkg::PWR_DOWN |=> rxLogicOe == '1 && !pumpOn)
        else $error("receivers off during auto powerdown");
    a_present_rise: assert property (s_line_arrives |-> arriveRun_q <= VALID_LAST)
        else $error("line_present late on arrival");
    a_present_fall: assert property ($fell(linePresent) |-> $past(presCnt_q) == INVALID_LAST && !$past(anyValid))
        else $error("line_present fell at wrong time");
    a_no_drv_in_down: assert property (pwr.state != stx_pkg::PWR_ACTIVE |=> txLineOe == '0)
        else $error("drivers on before wake complete");
    a_irq_level: assert property (irq == |(irqStat_q & irqMask_q))
        else $error("interrupt output mismatch");

    // Power mode checks
    a_wake_pump_on: assert property (shutdownN && pwr.state == stx_pkg::PWR_WAKING |=> pumpOn)
        else $error("pump off while waking");
    a_drv_on_active: assert property (shutdownN && pwr.state == stx_pkg::PWR_ACTIVE |=> txLineOe == '1)
        else $error("drivers off while active");
    a_hold_active: assert property (shutdownN && holdAwake && pwr.state == stx_pkg::PWR_ACTIVE |=>
        pwr.state == stx_pkg::PWR_ACTIVE)
        else $error("left active state while held awake");
    a_rx_on_run: assert property (shutdownN |=> rxLogicOe == '1)
        else $error("receivers off while not in shutdown");

    // Line status checks
    a_present_steady: assert property (anyValid == linePresent |=> $stable(linePresent))
        else $error("line_present changed without cause");
    a_present_edge: assert property ($rose(linePresent) |-> $past(presCnt_q) == VALID_LAST && $past(anyValid))
        else $error("line_present rose at wrong time");

    // Bus and interrupt checks
    a_apb_one_wait: assert property (s_apb_access |=> s_apb_answer)
        else $error("bus answer not after one wait cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("bus error without ready");
    a_event_kept: assert property (irqEvt != '0 |=> (irqStat_q & $past(irqEvt)) == $past(irqEvt))
        else $error("status event lost");
endmodule : stx_transceiver

// *** design/stx_pkg.sv ***
package stx_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned HZ_PER_MHZ = 1_000_000;

    function automatic int unsigned cyc_of_us(input int unsigned us);
        return (CLK_HZ / HZ_PER_MHZ) * us;
    endfunction : cyc_of_us

    // Inactivity window, typical figure; the device may take 15 to 60 s
    localparam int unsigned IDLE_S = 30;
    localparam int unsigned IDLE_MIN_S = 15;
    localparam int unsigned IDLE_MAX_S = 60;
    localparam int unsigned IDLE_CYC = IDLE_S * CLK_HZ;
    localparam int unsigned IDLE_MIN_CYC = IDLE_MIN_S * CLK_HZ;
    localparam int unsigned IDLE_MAX_CYC = IDLE_MAX_S * CLK_HZ;

    localparam int unsigned WAKE_US = 30;
    localparam int unsigned WAKE_MAX_US = 150;
    localparam int unsigned WAKE_CYC = cyc_of_us(WAKE_US);
    localparam int unsigned VALID_US = 1;
    localparam int unsigned VALID_CYC = cyc_of_us(VALID_US);
    localparam int unsigned INVALID_US = 30;
    localparam int unsigned INVALID_CYC = cyc_of_us(INVALID_US);

    localparam int CNT_W = 32;
    localparam int DLY_W = 10;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_DOWN = 2'h1,
        PWR_WAKING = 2'h3
    } stx_pwr_state_t;

    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;

    localparam int CTRL_HOLD = 0;
    localparam int ST_PUMP = 0;
    localparam int ST_DRV = 1;
    localparam int ST_RCV = 2;
    localparam int ST_LINE = 3;
    localparam int ST_STATE = 4;

    localparam int IRQ_W = 4;
    localparam int IRQ_DOWN = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_LINE_UP = 2;
    localparam int IRQ_LINE_DN = 3;
    localparam logic CTRL_HOLD_RST = 1'h0;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
endpackage : stx_pkg

// *** design/stx_pwr_if.sv ***
`timescale 1ns/1ps
interface stx_pwr_if;
    logic activity;
    logic autoEn;
    logic enteredDown;
    logic wakeDone;
    stx_pkg::stx_pwr_state_t state;

    modport fsm(input activity, input autoEn, output enteredDown, output wakeDone, output state);
    modport user(output activity, output autoEn, input enteredDown, input wakeDone, input state);
endinterface : stx_pwr_if

// *** design/stx_pwr_fsm.sv ***
`timescale 1ns/1ps
module stx_pwr_fsm #(
    parameter int unsigned IDLE_CYCLES = stx_pkg::IDLE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    stx_pwr_if.fsm pwr
);
    localparam logic [stx_pkg::CNT_W-1:0] IDLE_LAST = stx_pkg::CNT_W'(IDLE_CYCLES - 1);
    localparam logic [stx_pkg::DLY_W-1:0] WAKE_LAST = stx_pkg::DLY_W'(stx_pkg::WAKE_CYC - 1);

    stx_pkg::stx_pwr_state_t state_q, state_d;
    logic [stx_pkg::CNT_W-1:0] idleCnt_q;
    logic [stx_pkg::DLY_W-1:0] wakeCnt_q;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            stx_pkg::PWR_ACTIVE: begin
                if (pwr.autoEn && !pwr.activity && idleCnt_q == IDLE_LAST) begin
                    state_d = stx_pkg::PWR_DOWN;
                end
            end
            stx_pkg::PWR_DOWN: begin
                if (pwr.activity || !pwr.autoEn) begin
                    state_d = stx_pkg::PWR_WAKING;
                end
            end
            stx_pkg::PWR_WAKING: begin
                if (wakeCnt_q == WAKE_LAST) begin
                    state_d = stx_pkg::PWR_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= stx_pkg::PWR_ACTIVE;
        end else begin
            state_q <= state_d;
        end
    end

    // Idle time restarts on any edge or while auto mode is off
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            idleCnt_q <= '0;
        end else if (pwr.activity || !pwr.autoEn || state_q != stx_pkg::PWR_ACTIVE) begin
            idleCnt_q <= '0;
        end else if (idleCnt_q != IDLE_LAST) begin
            idleCnt_q <= idleCnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n || state_q != stx_pkg::PWR_WAKING) begin
            wakeCnt_q <= '0;
        end else begin
            wakeCnt_q <= wakeCnt_q + 1'b1;
        end
    end

    assign pwr.state = state_q;
    assign pwr.enteredDown = state_q == stx_pkg::PWR_ACTIVE && state_d == stx_pkg::PWR_DOWN;
    assign pwr.wakeDone = state_q == stx_pkg::PWR_WAKING && state_d == stx_pkg::PWR_ACTIVE;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_woken;
        state_q == stx_pkg::PWR_DOWN && pwr.activity;
    endsequence
    sequence s_exit;
        state_q == stx_pkg::PWR_WAKING ##299 state_q == stx_pkg::PWR_WAKING
            ##1 state_q == stx_pkg::PWR_ACTIVE;
    endsequence

    a_wake_exit: assert property (s_woken |=> s_exit)
        else $error("wake exit not after 300 cycles");
    a_down_after_idle: assert property ($rose(state_q == stx_pkg::PWR_DOWN) |->
        $past(idleCnt_q) == IDLE_LAST && $past(pwr.autoEn))
        else $error("powerdown without full idle interval");
    a_hold_no_down: assert property (!pwr.autoEn && state_q != stx_pkg::PWR_DOWN |=>
        state_q != stx_pkg::PWR_DOWN)
        else $error("powerdown while auto mode disabled");
    a_idle_restart: assert property (pwr.activity |=> idleCnt_q == '0)
        else $error("idle timer not restarted by edge");
endmodule : stx_pwr_fsm

// *** verification/stx_ctrl_model.sv ***
`timescale 1ns/1ps
module stx_ctrl_model #(
    parameter int unsigned IDLE_CYCLES = 50
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [1:0] wantTx,
    input wire logic wantHold,
    input wire logic wantOn,
    input wire logic autoHold,
    output logic [1:0] txLogicIn,
    output logic holdAwake,
    output logic shutdownN
);
    logic [31:0] idle_q;
    logic late_q;
    logic [1:0] txPrev_q;

    always_ff @(posedge sys_clk) begin
        txPrev_q <= wantTx;
    end

    // Idle time since our own last transmit edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n || wantTx != txPrev_q) begin
            idle_q <= 32'h0;
        end else if (idle_q != 32'hffffffff) begin
            idle_q <= idle_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        late_q <= rst_n && idle_q >= IDLE_CYCLES / 2;
    end

    assign txLogicIn = wantTx;
    assign shutdownN = wantOn;
    assign holdAwake = wantHold | (autoHold & late_q);
endmodule : stx_ctrl_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
    localparam int unsigned IDLE = 50;
    logic sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'had76;
    logic pready, pslverr, err, wantHold = 1'b0, wantOn = 1'b1, autoHold = 1'b0;
    logic holdAwake, shutdownN, linePresent, pumpOn, irq;
    logic [1:0] wantTx = 2'h0, txLogicIn, rxLineIn = 2'h0, rxLineValid = 2'h3;
    logic [1:0] txLineOut, txLineOe, rxLogicOut, rxLogicOe;
    logic [2:0] mon;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n;

    assign mon = {linePresent, txLineOe[0], pumpOn};

    stx_ctrl_model #(.IDLE_CYCLES(IDLE)) i_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .wantTx(wantTx),
        .wantHold(wantHold), .wantOn(wantOn), .autoHold(autoHold), .txLogicIn(txLogicIn),
        .holdAwake(holdAwake), .shutdownN(shutdownN));

    stx_transceiver #(.IDLE_CYCLES(IDLE), .NUM_CH(2)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .txLogicIn(txLogicIn),
        .rxLineIn(rxLineIn), .rxLineValid(rxLineValid), .holdAwake(holdAwake),
        .shutdownN(shutdownN), .txLineOut(txLineOut), .txLineOe(txLineOe),
        .rxLogicOut(rxLogicOut), .rxLogicOe(rxLogicOe), .linePresent(linePresent),
        .pumpOn(pumpOn), .irq(irq));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // Open inputs read as high at the logic side
    function automatic logic [1:0] rx_exp(input logic [1:0] l, input logic [1:0] v);
        return ~l | ~v;
    endfunction : rx_exp

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rng(input string nm, input int lo, input int hi, input int g);
        comparisons++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : rng

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdchk

    task automatic count_until(input int sel, input logic val);
        n = 0;
        while (mon[sel] !== val && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask : count_until

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 10000) begin
            n_mismatch++;
            $display("Error timeout expected finish before %0d cycles seen %0d", 10000, cyc);
            print_verdict();
        end
    end

    initial begin
        logic [31:0] v;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk("ctrl_rst", stx_pkg::ADDR_CTRL, 32'h0);
        rdchk("mask_rst", stx_pkg::ADDR_IRQ_MASK, 32'h0);
        rdchk("unmapped_data", 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        for (int i = 0; i < 40; i++) begin
            v = xs();
            @(posedge sys_clk);
            wantTx <= v[1:0];
            rxLineIn <= v[3:2];
            rxLineValid <= (i < 4) ? 2'(i) : v[5:4];
            repeat (3) @(posedge sys_clk);
            #1;
            chk("tx_out", {30'h0, ~v[1:0]}, {30'h0, txLineOut});
            chk("rx_out", {30'h0, rx_exp(v[3:2], rxLineValid)}, {30'h0, rxLogicOut});
        end
        @(posedge sys_clk);
        rxLineValid <= 2'h3;
        wantHold <= 1'b1;
        repeat (450) @(posedge sys_clk);
        #1;
        chk("forced_on", 32'h7, {29'h0, rxLogicOe[0], txLineOe[0], pumpOn});
        rdchk("status_on", stx_pkg::ADDR_STATUS, 32'hf);
        apb(1'b0, stx_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq_clear", 32'h4, rd & 32'h4);
        apb(1'b1, stx_pkg::ADDR_IRQ_MASK, 32'h3);
        @(posedge sys_clk);
        wantHold <= 1'b0;
        wantTx <= ~wantTx;
        repeat (30) @(posedge sys_clk);
        wantTx <= ~wantTx;
        count_until(0, 1'b0);
        rng("idle_delay", IDLE, IDLE + 4, n);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("down_oe", 32'h32, {26'h0, rxLogicOe, txLineOe, irq, pumpOn});
        rdchk("stat_down", stx_pkg::ADDR_IRQ_STAT, 32'h1);
        rdchk("stat_clear", stx_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq_low", 32'h0, {31'h0, irq});
        @(posedge sys_clk);
        rxLineIn <= ~rxLineIn;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("rx_in_down", {30'h0, ~rxLineIn}, {30'h0, rxLogicOut});
        count_until(1, 1'b1);
        rng("wake_delay", 290, 1500, n);
        rdchk("stat_wake", stx_pkg::ADDR_IRQ_STAT, 32'h2);
        apb(1'b1, stx_pkg::ADDR_CTRL, 32'h1);
        rdchk("ctrl_wr", stx_pkg::ADDR_CTRL, 32'h1);
        @(posedge sys_clk);
        autoHold <= 1'b1;
        wantTx <= ~wantTx;
        apb(1'b1, stx_pkg::ADDR_CTRL, 32'h0);
        repeat (3 * IDLE) @(posedge sys_clk);
        #1;
        chk("late_hold", 32'h3, {30'h0, holdAwake, pumpOn});
        apb(1'b1, stx_pkg::ADDR_IRQ_MASK, 32'h0);
        @(posedge sys_clk);
        autoHold <= 1'b0;
        wantOn <= 1'b0;
        rxLineValid <= 2'h0;
        count_until(2, 1'b0);
        rng("invalid_delay", 299, 304, n);
        chk("shutdown", 32'h0, {26'h0, rxLogicOe, txLineOe, irq, pumpOn});
        @(posedge sys_clk);
        rxLineValid <= 2'h1;
        count_until(2, 1'b1);
        rng("valid_delay", 9, 13, n);
        apb(1'b0, stx_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("stat_line", 32'hc, rd & 32'hc);
        chk("irq_masked", 32'h0, {31'h0, irq});
        @(posedge sys_clk);
        wantOn <= 1'b1;
        repeat (5) @(posedge sys_clk);
        print_verdict();
    end
endmodule : tb
